// ===== dts_pkg.sv
/*
 * Shared constants and types for the dual timer status and control block:
 * register offsets, field positions, reset values, pin action codes and
 * the per-channel timer input carrier.
 * Assumes a 32-bit AXI4-Lite register bus and two 8-bit timer channels.
 */
package dts_pkg;

    localparam int DTS_NUM_CHAN = 2;
    localparam int DTS_CHAN_A = 0;
    localparam int DTS_CHAN_B = 1;
    localparam int DTS_CNT_W = 8;

    localparam logic [3:0] DTS_OFS_TIMER_A = 4'h0;
    localparam logic [3:0] DTS_OFS_TIMER_B = 4'h4;
    localparam logic [3:0] DTS_OFS_PIN_STATUS = 4'h8;

    localparam int DTS_BIT_MATCH_B_FLAG = 7;
    localparam int DTS_BIT_MATCH_A_FLAG = 6;
    localparam int DTS_BIT_WRAP_FLAG = 5;
    localparam int DTS_BIT_CAPTURE = 4;
    localparam int DTS_BIT_MATCH_B_ACT_LO = 2;
    localparam int DTS_BIT_MATCH_A_ACT_LO = 0;

    localparam logic [7:0] DTS_CTRL_RESET = 8'h00;
    localparam logic [7:0] DTS_FLAG_MASK_A = 8'hF0;
    localparam logic [7:0] DTS_FLAG_MASK_B = 8'hE0;
    localparam logic [7:0] DTS_WRAP_FROM = 8'hFF;
    localparam logic [7:0] DTS_WRAP_TO = 8'h00;

    localparam logic [1:0] DTS_RESP_OKAY = 2'h0;
    localparam logic [1:0] DTS_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DTS_ACT_KEEP = 2'h0,
        DTS_ACT_LOW = 2'h1,
        DTS_ACT_HIGH = 2'h2,
        DTS_ACT_TOGGLE = 2'h3
    } dts_pin_act_t;

    typedef enum logic [1:0] {
        DTS_CAP_WAIT_RISE = 2'h1,
        DTS_CAP_WAIT_FALL = 2'h2
    } dts_cap_state_t;

    typedef struct packed {
        logic [DTS_CNT_W-1:0] counter;
        logic [DTS_CNT_W-1:0] compare_a;
        logic [DTS_CNT_W-1:0] compare_b;
    } dts_chan_in_t;

endpackage : dts_pkg

// ===== dts_pin.sv
/*
 * Output pin driver of one timer channel: applies the selected action on
 * a compare-match B and on a compare-match A event.
 * Assumes one-cycle event pulses from the status logic.
 */
module dts_pin (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic match_a_evt,
    input wire logic match_b_evt,
    input wire dts_pkg::dts_pin_act_t match_a_act,
    input wire dts_pkg::dts_pin_act_t match_b_act,
    output logic pin
);
    import dts_pkg::*;

    logic pin_ff;
    logic mid;
    logic nxt_pin;

    function automatic logic apply_act(input dts_pin_act_t act, input logic cur);
        logic res;
        res = cur;
        unique case (act)
            DTS_ACT_KEEP: res = cur;
            DTS_ACT_LOW: res = 1'b0;
            DTS_ACT_HIGH: res = 1'b1;
            DTS_ACT_TOGGLE: res = ~cur;
        endcase
        return res;
    endfunction : apply_act

    // match B acts first, match A acts on its result
    always_comb begin
        mid = match_b_evt ? apply_act(match_b_act, pin_ff) : pin_ff;
        nxt_pin = match_a_evt ? apply_act(match_a_act, mid) : mid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
        end
    end

    assign pin = pin_ff;

endmodule : dts_pin

// ===== dts_top.sv
/*
 * Status and control logic of two 8-bit timer channels, A and B:
 * compare-match and wrap flags, channel A capture flag, capture interrupt
 * request and compare-match driven output pins, with an AXI4-Lite slave.
 * Assumes counters and compare registers live outside and their values
 * arrive synchronous to aclk; the capture input is synchronous too.
 */
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
module dts_top #(
    parameter int ADDR_W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dts_pkg::dts_chan_in_t chan_a_timer,
    input wire dts_pkg::dts_chan_in_t chan_b_timer,
    input wire logic chan_a_ext_reset,
    output logic chan_a_out_pin,
    output logic chan_b_out_pin,
    output logic capture_irq_request
);
    import dts_pkg::*;

    // write channel state
    logic awready_ff;
    logic wready_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [7:0] w_data_ff;
    logic w_lane0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;

    // read channel state
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic do_write;
    logic do_read;
    logic wr_mapped;
    logic rd_mapped;
    logic [3:0] wr_ofs;
    logic [3:0] rd_ofs;
    logic [DTS_NUM_CHAN-1:0] wr_hit;
    logic [DTS_NUM_CHAN-1:0] rd_hit;
    logic [31:0] nxt_rdata;

    // per-channel register and event state
    dts_chan_in_t [DTS_NUM_CHAN-1:0] chan_timer;
    logic [7:0] ctrl_ff [DTS_NUM_CHAN];
    logic [7:0] nxt_ctrl [DTS_NUM_CHAN];
    logic [7:4] arm_ff [DTS_NUM_CHAN];
    logic [DTS_NUM_CHAN-1:0] eq_a_prev_ff;
    logic [DTS_NUM_CHAN-1:0] eq_b_prev_ff;
    logic [DTS_CNT_W-1:0] cnt_prev_ff [DTS_NUM_CHAN];
    logic [DTS_NUM_CHAN-1:0] eq_a;
    logic [DTS_NUM_CHAN-1:0] eq_b;
    logic [DTS_NUM_CHAN-1:0] match_a_evt;
    logic [DTS_NUM_CHAN-1:0] match_b_evt;
    logic [DTS_NUM_CHAN-1:0] wrap_evt;
    logic [DTS_NUM_CHAN-1:0] pin_out;

    // capture detector state
    dts_cap_state_t cap_state_ff;
    dts_cap_state_t nxt_cap_state;
    logic ext_prev_ff;
    logic cap_evt;
    logic irq_ff;

    assign chan_timer[DTS_CHAN_A] = chan_a_timer;
    assign chan_timer[DTS_CHAN_B] = chan_b_timer;

    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign do_read = s_axi_arvalid && arready_ff;
    assign wr_ofs = {aw_addr_ff[3:2], 2'b00};
    assign rd_ofs = {s_axi_araddr[3:2], 2'b00};

    always_comb begin
        wr_mapped = (ADDR_W <= 4 || aw_addr_ff[ADDR_W-1:2] <= DTS_OFS_PIN_STATUS[3:2])
            && wr_ofs <= DTS_OFS_PIN_STATUS;
        rd_mapped = (ADDR_W <= 4 || s_axi_araddr[ADDR_W-1:2] <= DTS_OFS_PIN_STATUS[3:2])
            && rd_ofs <= DTS_OFS_PIN_STATUS;
        wr_hit[DTS_CHAN_A] = do_write && w_lane0_ff && wr_mapped && wr_ofs == DTS_OFS_TIMER_A;
        wr_hit[DTS_CHAN_B] = do_write && w_lane0_ff && wr_mapped && wr_ofs == DTS_OFS_TIMER_B;
        rd_hit[DTS_CHAN_A] = do_read && rd_mapped && rd_ofs == DTS_OFS_TIMER_A;
        rd_hit[DTS_CHAN_B] = do_read && rd_mapped && rd_ofs == DTS_OFS_TIMER_B;
    end

    // write address: held until the data has also arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            awready_ff <= 1'b1;
        end
    end

    // write data: only byte lane 0 carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
            w_data_ff <= 8'h00;
            w_lane0_ff <= 1'b0;
        end else if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata[7:0];
            w_lane0_ff <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            wready_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= DTS_RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? DTS_RESP_OKAY : DTS_RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (rd_ofs == DTS_OFS_TIMER_A) begin
            nxt_rdata[7:0] = ctrl_ff[DTS_CHAN_A];
        end else if (rd_ofs == DTS_OFS_TIMER_B) begin
            nxt_rdata[7:0] = ctrl_ff[DTS_CHAN_B];
        end else if (rd_ofs == DTS_OFS_PIN_STATUS) begin
            nxt_rdata[0] = pin_out[DTS_CHAN_A];
            nxt_rdata[1] = pin_out[DTS_CHAN_B];
            nxt_rdata[2] = irq_ff;
            nxt_rdata[3] = (cap_state_ff == DTS_CAP_WAIT_FALL);
        end
        if (!rd_mapped) begin
            nxt_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= DTS_RESP_OKAY;
        end else if (do_read) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= rd_mapped ? DTS_RESP_OKAY : DTS_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // capture: a rising edge, then a falling edge, on the external input
    always_comb begin
        nxt_cap_state = cap_state_ff;
        cap_evt = 1'b0;
        unique case (cap_state_ff)
            DTS_CAP_WAIT_RISE: begin
                if (chan_a_ext_reset && !ext_prev_ff) begin
                    nxt_cap_state = DTS_CAP_WAIT_FALL;
                end
            end
            DTS_CAP_WAIT_FALL: begin
                if (!chan_a_ext_reset && ext_prev_ff) begin
                    nxt_cap_state = DTS_CAP_WAIT_RISE;
                    cap_evt = 1'b1;
                end
            end
            default: begin
                nxt_cap_state = DTS_CAP_WAIT_RISE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_state_ff <= DTS_CAP_WAIT_RISE;
        end else begin
            cap_state_ff <= nxt_cap_state;
        end
    end

    // input history for the edge detector, reset to the idle level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= chan_a_ext_reset;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DTS_NUM_CHAN; gi++) begin : g_chan
            localparam logic [7:0] FLAG_MASK = (gi == DTS_CHAN_A) ? DTS_FLAG_MASK_A : DTS_FLAG_MASK_B;

            // flags react to the first cycle of a match, not to a long match
            assign eq_a[gi] = chan_timer[gi].counter == chan_timer[gi].compare_a;
            assign eq_b[gi] = chan_timer[gi].counter == chan_timer[gi].compare_b;
            assign match_a_evt[gi] = eq_a[gi] && !eq_a_prev_ff[gi];
            assign match_b_evt[gi] = eq_b[gi] && !eq_b_prev_ff[gi];
            assign wrap_evt[gi] = cnt_prev_ff[gi] == DTS_WRAP_FROM && chan_timer[gi].counter == DTS_WRAP_TO;

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    eq_a_prev_ff[gi] <= 1'b0;
                    eq_b_prev_ff[gi] <= 1'b0;
                end else begin
                    eq_a_prev_ff[gi] <= eq_a[gi];
                    eq_b_prev_ff[gi] <= eq_b[gi];
                end
            end

            // counter history for wrap detection
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_prev_ff[gi] <= DTS_WRAP_TO;
                end else begin
                    cnt_prev_ff[gi] <= chan_timer[gi].counter;
                end
            end

            always_comb begin
                nxt_ctrl[gi] = ctrl_ff[gi];
                if (wr_hit[gi]) begin
                    for (int b = DTS_BIT_CAPTURE; b <= DTS_BIT_MATCH_B_FLAG; b++) begin
                        if (FLAG_MASK[b]) begin
                            // only a zero after a read of one clears; a one is ignored
                            if (arm_ff[gi][b] && !w_data_ff[b]) begin
                                nxt_ctrl[gi][b] = 1'b0;
                            end
                        end else begin
                            nxt_ctrl[gi][b] = w_data_ff[b];
                        end
                    end
                    nxt_ctrl[gi][3:0] = w_data_ff[3:0];
                end
                // setting events come last so that they win over a clear
                if (match_b_evt[gi]) begin
                    nxt_ctrl[gi][DTS_BIT_MATCH_B_FLAG] = 1'b1;
                end
                if (match_a_evt[gi]) begin
                    nxt_ctrl[gi][DTS_BIT_MATCH_A_FLAG] = 1'b1;
                end
                if (wrap_evt[gi]) begin
                    nxt_ctrl[gi][DTS_BIT_WRAP_FLAG] = 1'b1;
                end
                if (gi == DTS_CHAN_A && cap_evt) begin
                    nxt_ctrl[gi][DTS_BIT_CAPTURE] = 1'b1;
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ctrl_ff[gi] <= DTS_CTRL_RESET;
                end else begin
                    ctrl_ff[gi] <= nxt_ctrl[gi];
                end
            end

            // a read arms clearing of the flags it saw as one
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    arm_ff[gi] <= 4'h0;
                end else if (rd_hit[gi]) begin
                    arm_ff[gi] <= ctrl_ff[gi][7:4] & FLAG_MASK[7:4];
                end else if (wr_hit[gi]) begin
                    arm_ff[gi] <= 4'h0;
                end
            end

            dts_pin u_pin (
                .aclk(aclk),
                .aresetn(aresetn),
                .match_a_evt(match_a_evt[gi]),
                .match_b_evt(match_b_evt[gi]),
                .match_a_act(dts_pin_act_t'(ctrl_ff[gi][DTS_BIT_MATCH_A_ACT_LO +: 2])),
                .match_b_act(dts_pin_act_t'(ctrl_ff[gi][DTS_BIT_MATCH_B_ACT_LO +: 2])),
                .pin(pin_out[gi])
            );
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= ctrl_ff[DTS_CHAN_A][DTS_BIT_CAPTURE] && ctrl_ff[DTS_CHAN_B][DTS_BIT_CAPTURE];
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign chan_a_out_pin = pin_out[DTS_CHAN_A];
    assign chan_b_out_pin = pin_out[DTS_CHAN_B];
    assign capture_irq_request = irq_ff;

endmodule : dts_top

// ===== dts_top_properties.sv
/*
 * Concurrent checks on the ports of the dual timer status block.
 * Assumes one clock aclk and a synchronous active-low reset aresetn.
 */
module dts_top_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dts_pkg::dts_chan_in_t chan_a_timer,
    input wire dts_pkg::dts_chan_in_t chan_b_timer,
    input wire logic chan_a_out_pin,
    input wire logic chan_b_out_pin,
    input wire logic capture_irq_request
);
    timeunit 1ns;
    timeprecision 1ps;
    import dts_pkg::*;
    // equality history, cleared by reset like the block's own
    logic [3:0] eq_prev_ff;
    wire logic [3:0] eq_now = {chan_b_timer.counter == chan_b_timer.compare_b,
        chan_b_timer.counter == chan_b_timer.compare_a,
        chan_a_timer.counter == chan_a_timer.compare_b,
        chan_a_timer.counter == chan_a_timer.compare_a};
    wire logic [3:0] onset = eq_now & ~eq_prev_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eq_prev_ff <= '0;
        end else begin
            eq_prev_ff <= eq_now;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_block: assert property (p_w_block) else $error("write accepted while response pending");
    property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r_block: assert property (p_r_block) else $error("read accepted while data pending");
    property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_b_lat: assert property (p_b_lat) else $error("write response late");
    property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_pin_a; $changed(chan_a_out_pin) |-> $past(onset[0] || onset[1]); endproperty
    a_pin_a: assert property (p_pin_a) else $error("pin a moved without match");
    property p_pin_b; $changed(chan_b_out_pin) |-> $past(onset[2] || onset[3]); endproperty
    a_pin_b: assert property (p_pin_b) else $error("pin b moved without match");
    property p_irq_fall; $fell(capture_irq_request) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
endmodule : dts_top_chk

bind dts_top dts_top_chk chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .chan_a_timer(chan_a_timer),
    .chan_b_timer(chan_b_timer), .chan_a_out_pin(chan_a_out_pin), .chan_b_out_pin(chan_b_out_pin),
    .capture_irq_request(capture_irq_request));

// ===== tb.sv
/*
 * Self-checking bench for the dual timer status block: AXI4-Lite tasks,
 * timer inputs driven directly, expected values worked out here.
 * Assumes the 50 MHz clock and synchronous active-low reset.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dts_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ext, pin_a, pin_b, irq;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    dts_chan_in_t tim [2];
    int n_fail = 0;
    int comparisons = 0;
    logic [31:0] d;
    logic [1:0] r;
    logic [1:0] codes [5] = '{2'h2, 2'h0, 2'h3, 2'h2, 2'h1};
    logic exp_pin;
    dts_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .chan_a_timer(tim[0]), .chan_b_timer(tim[1]), .chan_a_ext_reset(ext),
        .chan_a_out_pin(pin_a), .chan_b_out_pin(pin_b), .capture_irq_request(irq));
    always #10 aclk = ~aclk;
    task automatic close_out();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic timed_out();
        n_fail++;
        $display("MISMATCH t=%0t bus wait ran out", $time);
        close_out();
    endtask : timed_out
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) timed_out();
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) timed_out();
        rready <= 1'b0;
        v = rdata;
        rs = rresp;
    endtask : axi_rd
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        axi_rd(a, d, r);
        chk(d, {24'h0, exp}, "register");
        chk({30'h0, r}, {30'h0, DTS_RESP_OKAY}, "rresp");
    endtask : rd_chk
    task automatic set_cnt(input logic [7:0] v);
        tim[0].counter <= v;
        tim[1].counter <= v;
        @(posedge aclk);
    endtask : set_cnt
    task automatic pulse(input int ch, input int m);
        tim[ch].counter <= (m != 0) ? tim[ch].compare_b : tim[ch].compare_a;
        @(posedge aclk);
        tim[ch].counter <= 8'h10;
        repeat (3) @(posedge aclk);
    endtask : pulse
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, ext} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        tim[0] = '{counter: 8'h10, compare_a: 8'h20, compare_b: 8'h30};
        tim[1] = '{counter: 8'h10, compare_a: 8'h20, compare_b: 8'h30};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(DTS_OFS_TIMER_A, 8'h00);
        rd_chk(DTS_OFS_TIMER_B, 8'h00);
        rd_chk(DTS_OFS_PIN_STATUS, 8'h00);
        axi_wr(4'hC, 8'h00, DTS_RESP_SLVERR);
        axi_rd(4'hC, d, r);
        chk({30'h0, r}, {30'h0, DTS_RESP_SLVERR}, "unmapped rresp");
        chk(d, 32'h0, "unmapped data");
        // compare-match B, compare-match A, then a wrap on both channels
        set_cnt(8'h30);
        set_cnt(8'h20);
        set_cnt(8'hFF);
        set_cnt(8'h00);
        set_cnt(8'h10);
        rd_chk(DTS_OFS_TIMER_A, 8'hE0);
        rd_chk(DTS_OFS_TIMER_B, 8'hE0);
        for (int i = 0; i < 2; i++) begin
            axi_wr((i != 0) ? DTS_OFS_TIMER_B : DTS_OFS_TIMER_A, 8'hE0, DTS_RESP_OKAY);
            axi_wr((i != 0) ? DTS_OFS_TIMER_B : DTS_OFS_TIMER_A, 8'h00, DTS_RESP_OKAY);
            rd_chk((i != 0) ? DTS_OFS_TIMER_B : DTS_OFS_TIMER_A, 8'hE0);
            axi_wr((i != 0) ? DTS_OFS_TIMER_B : DTS_OFS_TIMER_A, 8'h60, DTS_RESP_OKAY);
            rd_chk((i != 0) ? DTS_OFS_TIMER_B : DTS_OFS_TIMER_A, 8'h60);
            axi_wr((i != 0) ? DTS_OFS_TIMER_B : DTS_OFS_TIMER_A, 8'h00, DTS_RESP_OKAY);
            rd_chk((i != 0) ? DTS_OFS_TIMER_B : DTS_OFS_TIMER_A, 8'h00);
        end
        // capture: rise then fall on the external input
        ext <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(DTS_OFS_PIN_STATUS, 8'h08);
        ext <= 1'b0;
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        rd_chk(DTS_OFS_TIMER_A, 8'h10);
        axi_wr(DTS_OFS_TIMER_B, 8'h10, DTS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1, "irq enabled");
        rd_chk(DTS_OFS_PIN_STATUS, 8'h04);
        rd_chk(DTS_OFS_TIMER_B, 8'h10);
        axi_wr(DTS_OFS_TIMER_A, 8'h00, DTS_RESP_OKAY);
        rd_chk(DTS_OFS_TIMER_A, 8'h00);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        axi_wr(DTS_OFS_TIMER_B, 8'h00, DTS_RESP_OKAY);
        // every pin action code, for both matches on both channels
        for (int ch = 0; ch < 2; ch++) begin
            exp_pin = 1'b0;
            for (int m = 0; m < 2; m++) begin
                for (int k = 0; k < 5; k++) begin
                    axi_wr((ch != 0) ? DTS_OFS_TIMER_B : DTS_OFS_TIMER_A,
                        (m != 0) ? {4'h0, codes[k], 2'h0} : {6'h0, codes[k]}, DTS_RESP_OKAY);
                    pulse(ch, m);
                    case (codes[k])
                        DTS_ACT_LOW: exp_pin = 1'b0;
                        DTS_ACT_HIGH: exp_pin = 1'b1;
                        DTS_ACT_TOGGLE: exp_pin = ~exp_pin;
                        default: exp_pin = exp_pin;
                    endcase
                    chk({31'h0, (ch != 0) ? pin_b : pin_a}, {31'h0, exp_pin}, "pin");
                end
            end
        end
        // a clearing write meets a new compare-match A in the same cycle
        rd_chk(DTS_OFS_TIMER_A, 8'hC4);
        fork
            axi_wr(DTS_OFS_TIMER_A, 8'h00, DTS_RESP_OKAY);
            begin
                repeat (2) @(posedge aclk);
                tim[0].counter <= tim[0].compare_a;
                @(posedge aclk);
                tim[0].counter <= 8'h10;
            end
        join
        rd_chk(DTS_OFS_TIMER_A, 8'h40);
        close_out();
    end
endmodule : tb
